// File: rtl/supervisor_defines.svh
// Notes on behaviour
// - Reset held while manual reset low, then timeout.
// - Power-fail flag low while sense is low.
// - Watchdog overflows after timeout without kick edge.
// - Flag stays low until a kick edge, or on A a manual reset, clears the timer.
// - Timer clears on kick edge, undervoltage, manual reset.
// - Timer cleared during reset, counts after release.
// - Reset variant pulses reset on overflow.
// - Watchdog cannot be disabled.
// - Undervoltage on any monitored supply asserts reset.
// - Reset held about 200ms after conditions end.
// - New undervoltage restarts the reset timeout.
// - Active-high reset complements active-low reset.
// - Standard flag latches on overflow, undervoltage, manual.
// - Standard flag releases only on kick edge.
// - A flag follows undervoltage, releases immediately.
// - A flag latches on watchdog overflow.
// - A latched flag releases on kick or manual.
// - Kick pulses of 50ns are recognised.
`ifndef SUPERVISOR_DEFINES_SVH
`define SUPERVISOR_DEFINES_SVH

`define CLK_PERIOD_NS      10
`define TICK_PERIOD_NS     1000
`define TICK_CYCLES        (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define RESET_TIMEOUT_MS   200
`define RESET_TIMEOUT_TICKS (`RESET_TIMEOUT_MS * 1000)
`define WATCHDOG_TIMEOUT_MS 1600
`define WATCHDOG_TIMEOUT_TICKS (`WATCHDOG_TIMEOUT_MS * 1000)
`define KICK_MIN_PULSE_NS  50

`endif

// File: rtl/supervisor_pkg.sv
package supervisor_pkg;
   typedef enum logic [1:0]
   {
      RST_HOLD  = 2'b00,
      RST_TIMER = 2'b01,
      RST_IDLE  = 2'b11
   } reset_state_t;
endpackage

// File: rtl/sync_two_ff.sv
`timescale 1ns/1ps
module sync_two_ff #(
   parameter int WIDTH = 1
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         meta_q   <= '1;
         sync_out <= '1;
      end
      else
      begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// File: rtl/tick_divider.sv
`timescale 1ns/1ps
`include "supervisor_defines.svh"
module tick_divider #(
   parameter int CYCLES = `TICK_CYCLES
) (
   input  wire logic core_clk,
   input  wire logic rst,
   output logic      tick
);
   logic [15:0] cnt_q;
   wire         wrap = (cnt_q == 16'(CYCLES - 1));

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_q <= 16'h0000;
         tick  <= 1'b0;
      end
      else
      begin
         cnt_q <= wrap ? 16'h0000 : 16'(cnt_q + 16'h0001);
         tick  <= wrap;
      end
   end
endmodule

// File: rtl/supervisor_watchdog_reset.sv
`timescale 1ns/1ps
`include "supervisor_defines.svh"
module supervisor_watchdog_reset
   import supervisor_pkg::*;
#(
   parameter bit          A_VARIANT      = 1'b0,
   parameter bit          WDOG_RESETS    = 1'b0,
   parameter bit          AUX_ENABLE     = 1'b1,
   parameter int unsigned TICK_CYCLES    = `TICK_CYCLES,
   parameter int unsigned RESET_TICKS    = `RESET_TIMEOUT_TICKS,
   parameter int unsigned WATCHDOG_TICKS = `WATCHDOG_TIMEOUT_TICKS
) (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic supply_ok,
   input  wire logic aux_supply_sense_a,
   input  wire logic aux_supply_sense_b,
   input  wire logic manual_reset_n,
   input  wire logic watchdog_kick_in,
   input  wire logic powerfail_sense_in,
   output logic      reset_out_n,
   output logic      reset_out,
   output logic      watchdog_flag_n,
   output logic      powerfail_flag_n
);

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [5:0] sync_w;

   sync_two_ff #(.WIDTH(6)) u_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .async_in ({supply_ok, aux_supply_sense_a, aux_supply_sense_b,
                  manual_reset_n, watchdog_kick_in, powerfail_sense_in}),
      .sync_out (sync_w)
   );

   wire vcc_ok_s = sync_w[5];
   wire aux_a_s  = sync_w[4];
   wire aux_b_s  = sync_w[3];
   wire mr_n_s   = sync_w[2];
   wire kick_s   = sync_w[1];
   wire pfi_s    = sync_w[0];

   logic tick;

   tick_divider #(.CYCLES(TICK_CYCLES)) u_tick (
      .core_clk (core_clk),
      .rst      (rst),
      .tick     (tick)
   );

   // ----------------------------------------------------------------
   // Condition decoding
   // ----------------------------------------------------------------
   logic kick_q;
   logic wd_over_q;

   wire undervolt = !vcc_ok_s || (AUX_ENABLE && (!aux_a_s || !aux_b_s));
   wire manual    = !mr_n_s;
   // any level change is an edge; 100 MHz sampling sees 50ns
   wire kick_edge = (kick_s != kick_q);
   wire wd_reset  = WDOG_RESETS && wd_over_q;
   // manual reset joins the reset sources
   wire reset_src = undervolt || manual || wd_reset;

   // ----------------------------------------------------------------
   // Reset pulse stretcher
   // ----------------------------------------------------------------
   reset_state_t state_q;
   reset_state_t state_d;
   logic [31:0]  rp_cnt_q;

   wire rp_done = (rp_cnt_q >= RESET_TICKS - 1) && tick;

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         RST_HOLD:  state_d = reset_src ? RST_HOLD : RST_TIMER;
         RST_TIMER: state_d = reset_src ? RST_HOLD :
                              (rp_done ? RST_IDLE : RST_TIMER);
         RST_IDLE:  state_d = reset_src ? RST_HOLD : RST_IDLE;
         default:   state_d = RST_HOLD;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         state_q <= RST_HOLD;
      else
         state_q <= state_d;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         rp_cnt_q <= 32'h0000_0000;
      else if (state_q != RST_TIMER || reset_src)
         rp_cnt_q <= 32'h0000_0000;
      else if (tick)
         rp_cnt_q <= 32'(rp_cnt_q + 32'h0000_0001);
   end

   wire reset_asserted = (state_d != RST_IDLE);

   // complementary outputs from the same state
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         reset_out_n <= 1'b0;
         reset_out   <= 1'b1;
      end
      else
      begin
         reset_out_n <= !reset_asserted;
         reset_out   <= reset_asserted;
      end
   end

   // ----------------------------------------------------------------
   // Watchdog timer
   // ----------------------------------------------------------------
   logic [31:0] wd_cnt_q;

   // clear sources; held clear in reset
   wire wd_clear = kick_edge || undervolt || manual || reset_asserted
                   || state_q != RST_IDLE;
   wire wd_wrap  = tick && (wd_cnt_q >= WATCHDOG_TICKS - 1);

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         kick_q <= 1'b1;
      else
         kick_q <= kick_s;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         wd_cnt_q <= 32'h0000_0000;
      else if (wd_clear || wd_wrap)
         wd_cnt_q <= 32'h0000_0000;
      else if (tick)
         wd_cnt_q <= 32'(wd_cnt_q + 32'h0000_0001);
   end

   // overflow pulse drives reset on the reset-based variant
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         wd_over_q <= 1'b0;
      else
         wd_over_q <= !wd_clear && wd_wrap;
   end

   // ----------------------------------------------------------------
   // Watchdog flag
   // ----------------------------------------------------------------
   logic wd_latch_q;
   logic wd_latch_d;

   // standard latches; released by kick only
   wire std_set   = wd_over_q || undervolt || manual;
   wire std_latch = std_set || (wd_latch_q && !kick_edge);
   // A latches on overflow; kick or manual releases
   wire a_latch   = wd_over_q || (wd_latch_q && !kick_edge && !manual);

   assign wd_latch_d = WDOG_RESETS ? 1'b0 :
                       (A_VARIANT ? a_latch : std_latch);

   // undervoltage drives the A flag directly
   wire flag_low = wd_latch_d || (A_VARIANT && undervolt);

   // flag stays low, reset untouched when separate
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         wd_latch_q      <= 1'b0;
         watchdog_flag_n <= 1'b1;
      end
      else
      begin
         wd_latch_q      <= wd_latch_d;
         watchdog_flag_n <= !flag_low;
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         powerfail_flag_n <= 1'b1;
      else
         powerfail_flag_n <= pfi_s;
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_reset_compl: assert property (reset_out == !reset_out_n)
      else $error("reset outputs not complementary");

   a_manual_holds: assert property (manual |=> !reset_out_n)
      else $error("manual reset did not hold reset");

   a_undervolt_rst: assert property (undervolt |=> !reset_out_n)
      else $error("undervoltage did not assert reset");

   a_pf_follows: assert property (powerfail_flag_n == $past(pfi_s))
      else $error("power-fail flag mismatch");

   a_timer_cleared: assert property (!reset_out_n |-> wd_cnt_q == 0)
      else $error("watchdog counted during reset");

   a_kick_clears: assert property (kick_edge |=> wd_cnt_q == 0)
      else $error("kick edge did not clear timer");

   a_restart_hold: assert property (
      (state_q == RST_TIMER && reset_src) |=> state_q == RST_HOLD)
      else $error("timeout not restarted");

   a_release_wait: assert property (
      $rose(reset_out_n) |-> $past(state_q == RST_TIMER))
      else $error("reset released without timeout");

   a_flag_overflow: assert property (
      (wd_over_q && !WDOG_RESETS) |=> !watchdog_flag_n)
      else $error("overflow did not assert flag");

   a_std_hold: assert property (
      (!A_VARIANT && !watchdog_flag_n && wd_latch_q && !kick_edge)
      |=> !watchdog_flag_n)
      else $error("standard flag released without kick");

   a_wd_resets: assert property (
      (wd_over_q && WDOG_RESETS) |=> !reset_out_n)
      else $error("overflow did not pulse reset");

   c_reset_release: cover property ($rose(reset_out_n));
   c_flag_low:      cover property ($fell(watchdog_flag_n));
   c_flag_release:  cover property ($rose(watchdog_flag_n));
   c_restart:       cover property (state_q == RST_TIMER && reset_src);

endmodule

// File: dv/cpu_kick_model.sv
`timescale 1ns/1ps
module cpu_kick_model #(
   parameter int HALF = 40
) (
   input  wire logic core_clk,
   input  wire logic kick_en,
   output logic      watchdog_kick_in
);
   int cnt;

   initial
   begin
      watchdog_kick_in = 1'b0;
      cnt = 0;
   end

   // toggle well inside period
   // Rising edge with non-blocking update: avoids racing the bench's
   // falling-edge writes of kick_en
   always @(posedge core_clk)
   begin
      if (kick_en)
      begin
         cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
         if (cnt == HALF - 1)
            watchdog_kick_in <= ~watchdog_kick_in;
      end
   end
endmodule

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic core_clk;
   logic rst;
   logic supply_ok;
   logic aux_a;
   logic aux_b;
   logic manual_reset_n;
   logic kick_en;
   logic kick;
   logic pf_sense;
   logic reset_out_n;
   logic reset_out;
   logic watchdog_flag_n;
   logic powerfail_flag_n;
   int   n_fail;
   int   tests_run;

   // -------------------------------------------------
   // Short counts: timeout 40 cycles, watchdog 120
   // -------------------------------------------------
   supervisor_watchdog_reset #(
      .TICK_CYCLES    (4),
      .RESET_TICKS    (10),
      .WATCHDOG_TICKS (30)
   ) uut (
      .core_clk           (core_clk),
      .rst                (rst),
      .supply_ok          (supply_ok),
      .aux_supply_sense_a (aux_a),
      .aux_supply_sense_b (aux_b),
      .manual_reset_n     (manual_reset_n),
      .watchdog_kick_in   (kick),
      .powerfail_sense_in (pf_sense),
      .reset_out_n        (reset_out_n),
      .reset_out          (reset_out),
      .watchdog_flag_n    (watchdog_flag_n),
      .powerfail_flag_n   (powerfail_flag_n)
   );

   cpu_kick_model kicker (
      .core_clk         (core_clk),
      .kick_en          (kick_en),
      .watchdog_kick_in (kick)
   );

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input logic got, input logic exp, input string m);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   // Reset must stay low min_c cycles, then rise before max_c
   task automatic expect_release(input int min_c, input int max_c);
      int i;
      for (i = 0; i < min_c; i++)
      begin
         cyc(1);
         check(reset_out_n, 1'b0, "reset released early");
         check(reset_out, ~reset_out_n, "outputs not paired");
      end
      while (reset_out_n !== 1'b1 && i < max_c)
      begin
         cyc(1);
         i++;
      end
      check(reset_out_n, 1'b1, "reset never released");
      check(reset_out, 1'b0, "active-high reset stuck");
   endtask

   task automatic set_src(input int s, input logic v);
      if (s == 0) supply_ok = v;
      else if (s == 1) aux_a = v;
      else aux_b = v;
   endtask

   task automatic test_manual();
      manual_reset_n = 1'b0;
      cyc(6);
      check(reset_out_n, 1'b0, "manual reset ignored");
      check(watchdog_flag_n, 1'b0, "flag not latched");
      cyc(20);
      manual_reset_n = 1'b1;
      expect_release(35, 55);
      cyc(100);
      check(watchdog_flag_n, 1'b1, "flag not freed by kick");
   endtask

   task automatic test_supplies();
      for (int s = 0; s < 3; s++)
      begin
         set_src(s, 1'b0);
         cyc(6);
         check(reset_out_n, 1'b0, "undervoltage ignored");
         set_src(s, 1'b1);
         cyc(20);
         set_src((s + 1) % 3, 1'b0);
         cyc(4);
         set_src((s + 1) % 3, 1'b1);
         expect_release(35, 55);
         cyc(100);
      end
   endtask

   task automatic test_powerfail();
      pf_sense = 1'b0;
      cyc(5);
      check(powerfail_flag_n, 1'b0, "power-fail flag high");
      check(reset_out_n, 1'b1, "power-fail reset");
      pf_sense = 1'b1;
      cyc(5);
      check(powerfail_flag_n, 1'b1, "power-fail flag low");
   endtask

   task automatic test_overflow();
      int i;
      @(kick);
      cyc(1);
      kick_en = 1'b0;
      cyc(105);
      check(watchdog_flag_n, 1'b1, "overflow too early");
      for (i = 0; i < 40 && watchdog_flag_n !== 1'b0; i++)
         cyc(1);
      check(watchdog_flag_n, 1'b0, "no overflow");
      cyc(10);
      check(watchdog_flag_n, 1'b0, "flag not held");
      check(reset_out_n, 1'b1, "overflow hit reset");
      kick_en = 1'b1;
      cyc(60);
      check(watchdog_flag_n, 1'b1, "kick did not free flag");
      check(reset_out_n, 1'b1, "reset after kick");
   endtask

   initial
   begin
      n_fail = 0;
      tests_run = 0;
      rst = 1'b1;
      supply_ok = 1'b1;
      aux_a = 1'b1;
      aux_b = 1'b1;
      manual_reset_n = 1'b1;
      kick_en = 1'b1;
      pf_sense = 1'b1;
      cyc(12);
      rst = 1'b0;
      expect_release(35, 55);
      cyc(100);
      test_manual();
      test_supplies();
      test_powerfail();
      test_overflow();
      results();
   end

   initial
   begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      results();
   end
endmodule
